/* shared/adc_port_pkg.sv */
package adc_port_pkg;
  localparam int CMD_W = 8;
  localparam int WORD_W = 24;
  localparam int SETUP_W = 72;
  localparam int CNT_W = 7;
  localparam int RUN_W = 4;
  localparam logic [7:0] RESYNC_ONE_BYTE = 8'hff;
  localparam logic [7:0] RESYNC_ZERO_BYTE = 8'hfe;
  localparam logic [3:0] RESYNC_MIN = 4'hf;
  localparam logic [2:0] RW_OPCODE = 3'h4;
  localparam int DIR_BIT = 4;
  localparam logic [2:0] SEL_OFFSET = 3'h0;
  localparam logic [2:0] SEL_GAIN = 3'h1;
  localparam logic [2:0] SEL_CONFIG = 3'h2;
  localparam logic [2:0] SEL_DATA = 3'h3;
  localparam logic [2:0] SEL_SETUP = 3'h4;
  localparam logic [23:0] OFFSET_RST = 24'h000000;
  localparam logic [23:0] GAIN_RST = 24'h400000;
  localparam logic [23:0] CONFIG_RST = 24'h000040;
  typedef enum logic [1:0] {ST_CMD = 2'b00, ST_WRITE = 2'b01, ST_READ = 2'b11} port_state_t;
endpackage

/* logic/adc_serial_command_port.sv */
`timescale 1ns/1ns
// Behaviour
// - With select tied low the port still works on clock and data lines alone.
// - Serial output is high impedance while select is high; it only returns data.
// - Serial clock edges are ignored while select is high.
// - Every transfer opens with an eight-bit command, most significant bit first.
// - Port enters command mode after reset and after a completed resync.
// - Fifteen or more all-ones bytes open the resync sequence.
// - A 0xfe byte after that run ends resync and returns to command mode.
// - In command mode all input bits are taken as command bytes.
// - Resync resets only port state; stored registers keep their values.
// - Command bit 4 picks direction: zero writes, one reads.
// - Select field picks offset, gain, configuration, data, or all three set-up registers.
module adc_serial_command_port
  import adc_port_pkg::*;
(
  // System.
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // Serial pins.
  input wire logic select_n_i,
  input wire logic serial_clk_i,
  input wire logic serial_in_line_i,
  output logic serial_out_line_o,
  output logic serial_out_line_oe_n_o,
  // Device side.
  input wire logic [23:0] conv_data_i,
  output logic [23:0] offset_o,
  output logic [23:0] gain_o,
  output logic [23:0] config_o
);
  logic [2:0] pin_meta, sync2;
  logic sclk_d, cs_d;
  logic rise, fall;
  port_state_t state, next_state;
  logic [71:0] shreg, next_shreg;
  logic [CNT_W-1:0] cnt, next_cnt;
  logic [CNT_W-1:0] bits, next_bits;
  logic [CNT_W-1:0] run, next_run;
  logic [2:0] sel, next_sel;
  logic [23:0] offset, next_offset, gain, next_gain, cfg, next_cfg;
  logic out_bit, next_out_bit;
  logic [7:0] byte_in;
  logic resync;
  localparam logic [CNT_W-1:0] RESYNC_RUN = CNT_W'(RESYNC_MIN * CMD_W + CMD_W - 1);

  always_ff @(posedge clk_i)
  begin
    pin_meta <= {select_n_i, serial_clk_i, serial_in_line_i};
    sync2 <= pin_meta;
    sclk_d <= sync2[1];
    cs_d <= sync2[2];
  end

  assign rise = !sync2[2] && !cs_d && sync2[1] && !sclk_d;
  assign fall = !sync2[2] && sync2[1] == 1'b0 && sclk_d;
  assign byte_in = {shreg[6:0], sync2[0]};
  assign resync = rise && !sync2[0] && run == RESYNC_RUN;

  always_comb
  begin
    next_state = state;
    next_shreg = shreg;
    next_cnt = cnt;
    next_bits = bits;
    next_run = run;
    next_sel = sel;
    next_offset = offset;
    next_gain = gain;
    next_cfg = cfg;
    next_out_bit = out_bit;
    if (rise)
    begin
      next_shreg = {shreg[70:0], sync2[0]};
      next_cnt = cnt + 1'b1;
      if (sync2[0])
        next_run = (run == RESYNC_RUN) ? run : run + 1'b1;
      else
        next_run = '0;
      if (state == ST_CMD && cnt == CNT_W'(CMD_W - 1))
      begin
        next_cnt = '0;
        if (byte_in[7:5] == RW_OPCODE && !byte_in[0] && byte_in[3:1] <= SEL_SETUP)
        begin
          next_sel = byte_in[3:1];
          next_bits = (byte_in[3:1] == SEL_SETUP) ? CNT_W'(SETUP_W) : CNT_W'(WORD_W);
          if (byte_in[DIR_BIT])
          begin
            next_state = ST_READ;
            unique case (byte_in[3:1])
              SEL_OFFSET: next_shreg = {offset, 48'h0};
              SEL_GAIN: next_shreg = {gain, 48'h0};
              SEL_CONFIG: next_shreg = {cfg, 48'h0};
              SEL_DATA: next_shreg = {conv_data_i, 48'h0};
              default: next_shreg = {offset, gain, cfg};
            endcase
          end
          else if (byte_in[3:1] != SEL_DATA)
            next_state = ST_WRITE;
        end
      end
      else if (state == ST_CMD && cnt == CNT_W'(CMD_W - 1) + 1'b1)
        next_cnt = '0;
      else if (state == ST_WRITE && cnt == bits - 1'b1)
      begin
        next_state = ST_CMD;
        next_cnt = '0;
        unique case (sel)
          SEL_OFFSET: next_offset = next_shreg[23:0];
          SEL_GAIN: next_gain = next_shreg[23:0];
          SEL_CONFIG: next_cfg = next_shreg[23:0];
          default:
          begin
            next_offset = next_shreg[71:48];
            next_gain = next_shreg[47:24];
            next_cfg = next_shreg[23:0];
          end
        endcase
      end
      else if (state == ST_READ)
      begin
        next_shreg = {shreg[70:0], 1'b0};
        if (cnt == bits - 1'b1)
        begin
          next_state = ST_CMD;
          next_cnt = '0;
        end
      end
      if (resync)
      begin
        next_state = ST_CMD;
        next_cnt = '0;
        next_offset = offset;
        next_gain = gain;
        next_cfg = cfg;
      end
    end
    if (fall || (state == ST_READ && cnt == '0))
      next_out_bit = (state == ST_READ) ? shreg[71] : 1'b0;
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      state <= ST_CMD;
      shreg <= '0;
      cnt <= '0;
      bits <= '0;
      run <= '0;
      sel <= SEL_OFFSET;
      offset <= OFFSET_RST;
      gain <= GAIN_RST;
      cfg <= CONFIG_RST;
      out_bit <= 1'b0;
    end
    else
    begin
      state <= next_state;
      shreg <= next_shreg;
      cnt <= next_cnt;
      bits <= next_bits;
      run <= next_run;
      sel <= next_sel;
      offset <= next_offset;
      gain <= next_gain;
      cfg <= next_cfg;
      out_bit <= next_out_bit;
    end
  end

  assign serial_out_line_o = out_bit;
  assign serial_out_line_oe_n_o = sync2[2] || state != ST_READ;
  assign offset_o = offset;
  assign gain_o = gain;
  assign config_o = cfg;

  sequence resync_end_s;
    rise && !sync2[0]
      && run == RESYNC_RUN;
  endsequence

  resync_cmd_mode_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    resync_end_s |=> state == ST_CMD && cnt == '0)
    else $error("Resync did not return to command mode.");

  resync_keeps_regs_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    resync_end_s |=> $stable(offset) && $stable(gain) && $stable(cfg))
    else $error("Resync changed a stored register.");

  out_hiz_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    sync2[2] |-> serial_out_line_oe_n_o)
    else $error("Serial output driven while deselected.");

  clk_ignored_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    sync2[2] |=> $stable(cnt) && $stable(state))
    else $error("Clock edge taken while deselected.");

  read_dir_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    rise && state == ST_CMD && cnt == CNT_W'(CMD_W - 1) && byte_in[7:5] == RW_OPCODE
      && !byte_in[0] && byte_in[DIR_BIT] && byte_in[3:1] <= SEL_SETUP |=> state == ST_READ)
    else $error("Read command not entered.");

  bad_cmd_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    rise && state == ST_CMD && cnt == CNT_W'(CMD_W - 1) && byte_in[0] |=> state == ST_CMD)
    else $error("Odd command left command mode.");

  word_len_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    $rose(state == ST_WRITE) |-> bits == ((sel == SEL_SETUP) ? CNT_W'(SETUP_W) : CNT_W'(WORD_W)))
    else $error("Wrong data word length.");

  cmd_count_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    state == ST_CMD |-> cnt < CNT_W'(CMD_W))
    else $error("Command byte counter overran.");

  read_oe_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    state == ST_READ && !sync2[2] |-> !serial_out_line_oe_n_o)
    else $error("Serial output not driven during a read.");

  run_clear_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    rise && !sync2[0] |=> run == '0)
    else $error("Ones run survived a zero bit.");
endmodule

/* bench/host_model.sv */
`timescale 1ns/1ns
// Host master model: owns select, serial clock and data in, samples data out.
module host_model (
  // Clock.
  input wire logic clk_i,
  // Serial pins.
  output logic select_n_o,
  output logic sclk_o,
  output logic serial_in_line_o,
  input wire logic serial_out_line_i
);
  initial
  begin
    select_n_o = 1'b1;
    sclk_o = 1'b0;
    serial_in_line_o = 1'b0;
  end
  // Shifts n bits of d MSB first; the clock idles low outside frames.
  task automatic xfer(input logic [191:0] d, input int n, input bit hold, input bit off,
    output logic [191:0] q);
    q = '0;
    @(posedge clk_i);
    select_n_o <= off;
    for (int i = 191; i > 191 - n; i--)
    begin
      sclk_o <= 1'b0;
      serial_in_line_o <= d[i];
      repeat (4) @(posedge clk_i);
      sclk_o <= 1'b1;
      repeat (2) @(posedge clk_i);
      q = {q[190:0], serial_out_line_i};
      repeat (2) @(posedge clk_i);
    end
    sclk_o <= 1'b0;
    serial_in_line_o <= ~serial_in_line_o;
    repeat (4) @(posedge clk_i);
    if (!hold)
      select_n_o <= 1'b1;
    repeat (4) @(posedge clk_i);
  endtask
endmodule

/* bench/adc_serial_command_port_test.sv */
`timescale 1ns/1ns
module adc_serial_command_port_test;
  import adc_port_pkg::*;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [23:0] conv_data_i = 24'h5a3c96;
  logic select_n, sclk, serial_in_line, serial_out_line, oe_n;
  logic [23:0] offset_o, gain_o, config_o;
  logic [191:0] q;
  int mismatches = 0;
  int n_checks = 0;
  wire logic serial_out_wire;
  assign serial_out_wire = oe_n ? 1'bz : serial_out_line;
  initial forever #10 clk_i = ~clk_i;
  adc_serial_command_port u_adc_serial_command_port (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .select_n_i(select_n), .serial_clk_i(sclk), .serial_in_line_i(serial_in_line),
    .serial_out_line_o(serial_out_line), .serial_out_line_oe_n_o(oe_n),
    .conv_data_i(conv_data_i),
    .offset_o(offset_o), .gain_o(gain_o), .config_o(config_o));
  host_model u_host_model (.clk_i(clk_i), .select_n_o(select_n), .sclk_o(sclk),
    .serial_in_line_o(serial_in_line), .serial_out_line_i(serial_out_wire));
  task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
    n_checks++;
    if (g !== e)
    begin
      $display("[ERR] %s expected %h seen %h", nm, e, g);
      mismatches++;
    end
  endtask
  task automatic results;
    if (mismatches == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic xf(input logic [7:0] c, input logic [71:0] d, input int n);
    u_host_model.xfer({c, d, 112'h0}, n + 8, 1'b0, 1'b0, q);
  endtask
  task automatic t_reset;
    chk("offset", OFFSET_RST, offset_o);
    chk("gain", GAIN_RST, gain_o);
    chk("config", CONFIG_RST, config_o);
    chk("oe_n", 24'h1, {23'h0, oe_n});
  endtask
  task automatic t_regs;
    logic [23:0] v;
    for (int s = 0; s < 3; s++)
    begin
      v = 24'ha5c300 + 24'(s);
      xf({3'b100, 1'b0, s[2:0], 1'b0}, {v, 48'h0}, 24);
      xf({3'b100, 1'b1, s[2:0], 1'b0}, '0, 24);
      chk("readback", v, q[23:0]);
    end
    chk("offset", 24'ha5c300, offset_o);
    chk("config", 24'ha5c302, config_o);
    xf(8'h96, '0, 24);
    chk("conv", 24'h5a3c96, q[23:0]);
    chk("oe_n", 24'h1, {23'h0, oe_n});
  endtask
  task automatic t_setup;
    xf(8'h88, 72'h111111_222222_333333, 72);
    chk("gain", 24'h222222, gain_o);
    xf(8'h98, '0, 72);
    chk("setup_off", 24'h111111, q[71:48]);
    chk("setup_cfg", 24'h333333, q[23:0]);
  endtask
  task automatic t_refuse;
    xf(8'h81, '0, 0);
    xf(8'h8a, '0, 0);
    xf(8'h86, '0, 0);
    u_host_model.xfer({8'h80, 24'hffffff, 160'h0}, 32, 1'b0, 1'b1, q);
    xf(8'h82, {24'h0f0f0f, 48'h0}, 24);
    chk("gain", 24'h0f0f0f, gain_o);
    chk("offset", 24'h111111, offset_o);
  endtask
  task automatic t_resync;
    u_host_model.xfer({8'h82, 8'ha5, {136{1'b1}}, 8'hfe, 8'h84, 24'h00c0de}, 192,
      1'b1, 1'b0, q);
    chk("gain", 24'ha5ffff, gain_o);
    chk("config", 24'h00c0de, config_o);
    chk("offset", 24'h111111, offset_o);
  endtask
  task automatic t_realign;
    u_host_model.xfer({3'b101, {15{8'hff}}, 8'hfe, 8'h80, 24'h00beef, 29'h0}, 163,
      1'b1, 1'b0, q);
    chk("realign_off", 24'h00beef, offset_o);
    u_host_model.xfer({8'h98, 13'h0, {15{8'hff}}, 8'hfe, 8'h84, 24'h0badc0, 11'h0}, 181,
      1'b0, 1'b0, q);
    chk("abort_cfg", 24'h0badc0, config_o);
    chk("abort_gain", 24'ha5ffff, gain_o);
  endtask
  initial
  begin
    repeat (5) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    t_reset();
    t_regs();
    t_setup();
    t_refuse();
    t_resync();
    t_realign();
    results();
  end
  initial
  begin
    repeat (20000) @(posedge clk_i);
    mismatches++;
    results();
  end
endmodule
